//--- verilog/sbn_map.svh
`ifndef SBN_MAP_SVH
`define SBN_MAP_SVH

`define SBN_OFF_NODE_ID 8'hE8
`define SBN_OFF_PHY_ACC 8'hEC
`define SBN_OFF_CYC_TIME 8'hF0
`define SBN_OFF_TIMER_CTL 8'hF4

`define SBN_NID_VALID_BIT 31
`define SBN_NID_ROOT_BIT 30
`define SBN_NID_CPS_BIT 27
`define SBN_NID_BUS_HI 15
`define SBN_NID_BUS_LO 6
`define SBN_NID_NODE_HI 5
`define SBN_NID_NODE_LO 0
`define SBN_BUS_INDEX_RST 10'h3FF
`define SBN_NODE_INDEX_RST 6'h3F
`define SBN_NODE_INDEX_MAX 6'h3F

`define SBN_PA_DONE_BIT 31
`define SBN_PA_RADDR_HI 27
`define SBN_PA_RADDR_LO 24
`define SBN_PA_RDATA_HI 23
`define SBN_PA_RDATA_LO 16
`define SBN_PA_RDREQ_BIT 15
`define SBN_PA_WRREQ_BIT 14
`define SBN_PA_TADDR_HI 11
`define SBN_PA_TADDR_LO 8
`define SBN_PA_WVAL_HI 7
`define SBN_PA_WVAL_LO 0

`define SBN_CT_SEC_HI 31
`define SBN_CT_SEC_LO 25
`define SBN_CT_CYC_HI 24
`define SBN_CT_CYC_LO 12
`define SBN_CT_OFF_HI 11
`define SBN_CT_OFF_LO 0
`define SBN_TICKS_PER_CYCLE 12'd3072
`define SBN_CYCLES_PER_SEC 13'd8000
`define SBN_SECONDS_MOD 8'd128

`define SBN_TC_SRC_BIT 22
`define SBN_TC_MASTER_BIT 21
`define SBN_TC_EN_BIT 20

`endif

//--- verilog/sbn_pkg.sv
package sbn_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] addr;
    logic [7:0] data;
  } sbn_phy_req_t;

  typedef struct packed {
    logic valid;
    logic [3:0] addr;
    logic [7:0] data;
  } sbn_phy_resp_t;

  typedef struct packed {
    logic bus_reset;
    logic node_arrive;
    logic [5:0] node_index;
    logic is_root;
    logic cable_power;
  } sbn_phy_stat_t;

  typedef struct packed {
    logic [6:0] second;
    logic [12:0] cycle;
    logic [11:0] offset;
  } sbn_cyc_time_t;

endpackage

//--- verilog/sbn_regs.sv
// Function
// RL1: Valid clears on bus reset, sets on node
// RL2: Root flag follows PHY root report
// RL3: Cable power flag follows PHY report
// RL4: Bus index writable, resets to ones
// RL5: Node index loaded from PHY after self-ID
// RL6: Software avoids async run at node 63
// RL7: Node identifier is bus over node
// RL8: Node identity reserved bits read zero
// RL9: Done clears on request, sets on response
// RL10: Capture returned PHY address and value
// RL11: Read request cleared once sent
// RL12: Write request cleared once sent
// RL13: Software never sets both requests
// RL14: Target address and write value, zero default
// RL15: Master sends timer in cycle start
// RL16: Non-master loads timer from cycle start
// RL17: Timer keeps counting locally when enabled
// RL18: Tick offset wraps modulo 3072
// RL19: Cycle index wraps modulo 8000
// RL20: Second count wraps modulo 128
// RL21: External reference clears tick offset
// RL22: Offset counts only while enabled
// RL23: Source select picks external rollover
// RL24: Master sends cycle start each rollover
// RL25: PHY response fields update together
`timescale 1ns/1ps
`default_nettype none
`include "sbn_map.svh"

module sbn_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire sbn_pkg::sbn_phy_stat_t phy_stat,
  output sbn_pkg::sbn_phy_req_t phy_req,
  input wire logic phy_req_accept,
  input wire sbn_pkg::sbn_phy_resp_t phy_resp,
  input wire logic tick_24m,
  input wire logic ext_rollover_in,
  input wire logic cs_rx_valid,
  input wire sbn_pkg::sbn_cyc_time_t cs_rx_time,
  output logic cs_tx_valid,
  output sbn_pkg::sbn_cyc_time_t cs_tx_time,
  output logic [15:0] node_id,
  output logic node_index_unusable
);

  function automatic logic hit(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] offset
  );
    hit = strobe && (addr == offset);
  endfunction

  logic wr_node;
  logic wr_phy;
  logic wr_time;
  logic wr_ctl;

  assign wr_node = hit(bus_wr, bus_addr, `SBN_OFF_NODE_ID);
  assign wr_phy = hit(bus_wr, bus_addr, `SBN_OFF_PHY_ACC);
  assign wr_time = hit(bus_wr, bus_addr, `SBN_OFF_CYC_TIME);
  assign wr_ctl = hit(bus_wr, bus_addr, `SBN_OFF_TIMER_CTL);

  // Node identity state
  logic node_id_valid;
  logic root;
  logic cable_power_ok;
  logic [9:0] bus_index;
  logic [5:0] phys_node_index;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      node_id_valid <= 1'b0;
    end else if (phy_stat.node_arrive) begin
      // A new number in the same cycle as a reset edge still counts
      node_id_valid <= 1'b1; // RL1
    end else if (phy_stat.bus_reset) begin
      node_id_valid <= 1'b0; // RL1
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      root <= 1'b0;
    end else if (phy_stat.node_arrive) begin
      root <= phy_stat.is_root; // RL2
    end else if (phy_stat.bus_reset) begin
      root <= 1'b0; // RL2
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cable_power_ok <= 1'b0;
    end else begin
      cable_power_ok <= phy_stat.cable_power; // RL3
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_index <= `SBN_BUS_INDEX_RST; // RL4
    end else if (wr_node) begin
      bus_index <= bus_wdata[`SBN_NID_BUS_HI:`SBN_NID_BUS_LO]; // RL4
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phys_node_index <= `SBN_NODE_INDEX_RST;
    end else if (phy_stat.node_arrive) begin
      phys_node_index <= phy_stat.node_index; // RL5
    end
  end

  assign node_id = {bus_index, phys_node_index}; // RL7
  // Flag for the transmit contexts, which must not run at this index
  assign node_index_unusable = (phys_node_index == `SBN_NODE_INDEX_MAX); // RL6

  // PHY register access state
  logic phy_access_done;
  logic [3:0] phy_return_addr;
  logic [7:0] phy_return_value;
  logic phy_read_req;
  logic phy_write_req;
  logic [3:0] phy_target_addr;
  logic [7:0] phy_write_value;
  logic sw_req;
  logic req_sent;

  assign sw_req = wr_phy && (bus_wdata[`SBN_PA_RDREQ_BIT] || bus_wdata[`SBN_PA_WRREQ_BIT]);
  assign req_sent = phy_req.valid && phy_req_accept;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phy_access_done <= 1'b0;
      phy_return_addr <= 4'h0;
      phy_return_value <= 8'h00;
    end else if (phy_resp.valid) begin
      // Response beats a concurrent request write so no answer is lost
      phy_access_done <= 1'b1; // RL9
      phy_return_addr <= phy_resp.addr; // RL10 RL25
      phy_return_value <= phy_resp.data; // RL10 RL25
    end else if (sw_req) begin
      phy_access_done <= 1'b0; // RL9
    end
  end

  // Both set is illegal; read wins so only one request goes out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phy_read_req <= 1'b0;
    end else if (wr_phy) begin
      phy_read_req <= bus_wdata[`SBN_PA_RDREQ_BIT]; // RL13
    end else if (req_sent) begin
      phy_read_req <= 1'b0; // RL11
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phy_write_req <= 1'b0;
    end else if (wr_phy) begin
      phy_write_req <= bus_wdata[`SBN_PA_WRREQ_BIT] && !bus_wdata[`SBN_PA_RDREQ_BIT]; // RL13
    end else if (req_sent) begin
      phy_write_req <= 1'b0; // RL12
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phy_target_addr <= 4'h0; // RL14
    end else if (wr_phy) begin
      phy_target_addr <= bus_wdata[`SBN_PA_TADDR_HI:`SBN_PA_TADDR_LO]; // RL14
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phy_write_value <= 8'h00; // RL14
    end else if (wr_phy) begin
      phy_write_value <= bus_wdata[`SBN_PA_WVAL_HI:`SBN_PA_WVAL_LO]; // RL14
    end
  end

  always_comb begin
    phy_req.valid = phy_read_req || phy_write_req; // RL11 RL12
    phy_req.write = phy_write_req;
    phy_req.addr = phy_target_addr; // RL14
    // Write value is not sent on a read
    phy_req.data = phy_write_req ? phy_write_value : 8'h00; // RL14
  end

  // Timer control
  logic rollover_source_sel;
  logic time_master_sel;
  logic tick_count_en;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rollover_source_sel <= 1'b0;
    end else if (wr_ctl) begin
      rollover_source_sel <= bus_wdata[`SBN_TC_SRC_BIT]; // RL23
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      time_master_sel <= 1'b0;
    end else if (wr_ctl) begin
      time_master_sel <= bus_wdata[`SBN_TC_MASTER_BIT]; // RL24
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_count_en <= 1'b0;
    end else if (wr_ctl) begin
      tick_count_en <= bus_wdata[`SBN_TC_EN_BIT]; // RL22
    end
  end

  // Cycle timer
  logic [6:0] time_second_count;
  logic [12:0] time_cycle_index;
  logic [11:0] time_tick_offset;
  logic next_rollover;
  logic int_wrap;
  logic ext_wrap;
  logic [11:0] next_offset;
  logic [12:0] next_cycle;
  logic [6:0] next_second;

  // Values loaded out of range wrap at the next step instead of running on
  function automatic logic at_last(
    input logic [12:0] value,
    input logic [12:0] last
  );
    at_last = value >= last;
  endfunction

  assign int_wrap = !rollover_source_sel && tick_count_en && tick_24m
    && at_last(13'(time_tick_offset), 13'(`SBN_TICKS_PER_CYCLE - 12'd1)); // RL18 RL23
  assign ext_wrap = rollover_source_sel && ext_rollover_in; // RL23
  assign next_rollover = int_wrap || ext_wrap;

  always_comb begin
    next_offset = time_tick_offset;
    next_cycle = time_cycle_index;
    next_second = time_second_count;
    if (next_rollover) begin
      next_offset = 12'h000; // RL18 RL21
      if (at_last(time_cycle_index, `SBN_CYCLES_PER_SEC - 13'd1)) begin
        next_cycle = 13'h0000; // RL19
        next_second = time_second_count + 7'd1; // RL20
      end else begin
        next_cycle = time_cycle_index + 13'd1; // RL19
      end
    end else if (tick_count_en && tick_24m) begin
      // External mode: hold at the top rather than wrap on a late reference
      if (time_tick_offset != 12'hFFF) begin
        next_offset = time_tick_offset + 12'd1; // RL17 RL22
      end
    end
  end

  logic cs_load;
  logic tx_now;

  // A master keeps its own time and ignores cycle starts it hears
  assign cs_load = cs_rx_valid && !time_master_sel; // RL16
  // A software timer write that cycle takes the place of the rollover
  assign tx_now = time_master_sel && next_rollover && !wr_time; // RL24

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      time_second_count <= 7'h00;
    end else if (wr_time) begin
      time_second_count <= bus_wdata[`SBN_CT_SEC_HI:`SBN_CT_SEC_LO];
    end else if (cs_load) begin
      time_second_count <= cs_rx_time.second; // RL16
    end else begin
      time_second_count <= next_second; // RL20
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      time_cycle_index <= 13'h0000;
    end else if (wr_time) begin
      time_cycle_index <= bus_wdata[`SBN_CT_CYC_HI:`SBN_CT_CYC_LO];
    end else if (cs_load) begin
      time_cycle_index <= cs_rx_time.cycle; // RL16
    end else begin
      time_cycle_index <= next_cycle; // RL19
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      time_tick_offset <= 12'h000;
    end else if (wr_time) begin
      time_tick_offset <= bus_wdata[`SBN_CT_OFF_HI:`SBN_CT_OFF_LO];
    end else if (cs_load) begin
      time_tick_offset <= cs_rx_time.offset; // RL16
    end else begin
      time_tick_offset <= next_offset; // RL17
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_tx_valid <= 1'b0;
    end else begin
      cs_tx_valid <= tx_now; // RL24
    end
  end

  // The sent time is the value the timer holds once the rollover lands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_tx_time <= '0;
    end else if (tx_now) begin
      cs_tx_time <= '{second: next_second, cycle: next_cycle, offset: next_offset}; // RL15
    end
  end

  // Read port: data one cycle after the strobe, zero otherwise
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h00000000;
    if (bus_rd) begin
      unique case (bus_addr)
        `SBN_OFF_NODE_ID: begin
          // Bits not placed here are reserved and stay zero
          next_rdata[`SBN_NID_VALID_BIT] = node_id_valid;
          next_rdata[`SBN_NID_ROOT_BIT] = root;
          next_rdata[`SBN_NID_CPS_BIT] = cable_power_ok;
          next_rdata[`SBN_NID_BUS_HI:`SBN_NID_NODE_LO] = node_id; // RL7 RL8
        end
        `SBN_OFF_PHY_ACC: begin
          next_rdata[`SBN_PA_DONE_BIT] = phy_access_done;
          next_rdata[`SBN_PA_RADDR_HI:`SBN_PA_RADDR_LO] = phy_return_addr;
          next_rdata[`SBN_PA_RDATA_HI:`SBN_PA_RDATA_LO] = phy_return_value;
          next_rdata[`SBN_PA_RDREQ_BIT] = phy_read_req;
          next_rdata[`SBN_PA_WRREQ_BIT] = phy_write_req;
          next_rdata[`SBN_PA_TADDR_HI:`SBN_PA_TADDR_LO] = phy_target_addr;
          next_rdata[`SBN_PA_WVAL_HI:`SBN_PA_WVAL_LO] = phy_write_value;
        end
        `SBN_OFF_CYC_TIME: begin
          next_rdata[`SBN_CT_SEC_HI:`SBN_CT_SEC_LO] = time_second_count;
          next_rdata[`SBN_CT_CYC_HI:`SBN_CT_CYC_LO] = time_cycle_index;
          next_rdata[`SBN_CT_OFF_HI:`SBN_CT_OFF_LO] = time_tick_offset;
        end
        `SBN_OFF_TIMER_CTL: begin
          next_rdata[`SBN_TC_SRC_BIT] = rollover_source_sel;
          next_rdata[`SBN_TC_MASTER_BIT] = time_master_sel;
          next_rdata[`SBN_TC_EN_BIT] = tick_count_en;
        end
        default: begin
          next_rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_rdata <= 32'h00000000;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

//--- tb/sbn_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sbn_regs_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire sbn_pkg::sbn_phy_stat_t phy_stat,
  input wire sbn_pkg::sbn_phy_req_t phy_req,
  input wire logic phy_req_accept,
  input wire logic cs_tx_valid,
  input wire sbn_pkg::sbn_cyc_time_t cs_tx_time,
  input wire logic [15:0] node_id,
  input wire logic node_index_unusable
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_RST: assert property (disable iff (1'b0) sys_rst |=> node_id == 16'hFFFF && !phy_req.valid)
    else $error("reset state wrong");
  AST_NID_RD: assert property (bus_rd && bus_addr == 8'hE8 |=> bus_rdata[29:28] == 2'h0 &&
    bus_rdata[26:16] == 11'h0 && bus_rdata[15:0] == $past(node_id)) else $error("node identity read wrong");
  AST_NODE: assert property (phy_stat.node_arrive |=> node_id[5:0] == $past(phy_stat.node_index))
    else $error("node index not loaded");
  AST_BUS: assert property (bus_wr && bus_addr == 8'hE8 |=> node_id[15:6] == $past(bus_wdata[15:6]))
    else $error("bus index not written");
  AST_UNUSE: assert property (node_index_unusable == (node_id[5:0] == 6'h3F))
    else $error("unusable flag wrong");
  AST_REQ_RD: assert property (bus_wr && bus_addr == 8'hEC && bus_wdata[15] |=> phy_req.valid &&
    !phy_req.write && phy_req.addr == $past(bus_wdata[11:8])) else $error("read request wrong");
  AST_REQ_WR: assert property (bus_wr && bus_addr == 8'hEC && bus_wdata[15:14] == 2'b01 |=>
    phy_req.valid && phy_req.write && phy_req.data == $past(bus_wdata[7:0])) else $error("write request wrong");
  AST_REQ_CLR: assert property (phy_req.valid && phy_req_accept && !(bus_wr && bus_addr == 8'hEC)
    |=> !phy_req.valid) else $error("request not cleared");
  AST_TX: assert property (cs_tx_valid |-> cs_tx_time.offset == 12'h0 &&
    cs_tx_time.cycle < 13'd8000) else $error("cycle start time wrong");
endmodule
bind sbn_regs sbn_regs_asserts sbn_regs_asserts_i (.clk, .sys_rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
  .bus_rdata, .phy_stat, .phy_req, .phy_req_accept, .cs_tx_valid, .cs_tx_time, .node_id, .node_index_unusable);
`default_nettype wire

//--- tb/sbn_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbn_phy_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire sbn_pkg::sbn_phy_req_t phy_req,
  output logic phy_req_accept,
  output sbn_pkg::sbn_phy_resp_t phy_resp
);
  logic [7:0] mem [16];
  logic [2:0] dly;
  logic [1:0] due;
  logic [3:0] ra;
  always_ff @(posedge clk) begin
    phy_req_accept <= 1'b0;
    phy_resp.valid <= 1'b0;
    // Idle lines toggle so a stale answer never looks valid
    phy_resp.addr <= ~phy_resp.addr;
    phy_resp.data <= ~phy_resp.data;
    if (sys_rst) begin
      dly <= 3'h0;
      due <= 2'h0;
      phy_resp <= '0;
    end else begin
      if (phy_req.valid && !phy_req_accept) begin
        dly <= dly + 3'h1;
        if (dly >= (slow ? 3'h3 : 3'h0)) begin
          phy_req_accept <= 1'b1;
          dly <= 3'h0;
          if (phy_req.write) begin
            mem[phy_req.addr] <= phy_req.data;
          end else begin
            due <= 2'h2;
            ra <= phy_req.addr;
          end
        end
      end
      if (due == 2'h1) begin
        phy_resp <= '{valid: 1'b1, addr: ra, data: mem[ra]};
      end
      if (due != 2'h0) begin
        due <= due - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, sys_rst, bus_wr, bus_rd, phy_req_accept, tick_24m, ext_rollover_in, cs_rx_valid, cs_tx_valid;
  logic node_index_unusable, slow;
  logic [7:0] bus_addr, d;
  logic [31:0] bus_wdata, bus_rdata, rv, w;
  logic [15:0] node_id;
  logic [5:0] idx;
  logic [3:0] a;
  sbn_pkg::sbn_phy_stat_t phy_stat;
  sbn_pkg::sbn_phy_req_t phy_req;
  sbn_pkg::sbn_phy_resp_t phy_resp;
  sbn_pkg::sbn_cyc_time_t cs_rx_time, cs_tx_time;
  int errors, num_checks, tx_seen;
  sbn_regs sbn_regs_i (.clk, .sys_rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .phy_stat, .phy_req,
    .phy_req_accept, .phy_resp, .tick_24m, .ext_rollover_in, .cs_rx_valid, .cs_rx_time, .cs_tx_valid,
    .cs_tx_time, .node_id, .node_index_unusable);
  sbn_phy_model sbn_phy_model_i (.clk, .sys_rst, .slow, .phy_req, .phy_req_accept, .phy_resp);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (cs_tx_valid === 1'b1) tx_seen++;
  function automatic logic [31:0] nid(logic v, logic r, logic c, logic [9:0] b, logic [5:0] n);
    return {v, r, 2'h0, c, 11'h0, b, n};
  endfunction
  function automatic logic [31:0] ctw(logic [6:0] s, logic [12:0] c, logic [11:0] o);
    return {s, c, o};
  endfunction
  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= ad;
    bus_wdata <= dt;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= ad;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 rv = bus_rdata;
  endtask
  // Done stays low until a response, so the first poll must see it clear
  task automatic poll(input int b, input logic v);
    for (int k = 0; k < 30; k++) begin
      rd(8'hEC);
      if (k == 0) ck("done_clr", 32'h0, {31'h0, rv[31]});
      if (rv[b] === v) return;
    end
    ck("poll", 32'h1, 32'h0);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    conclude();
  end
  initial begin
    sys_rst = 1'b1;
    {bus_wr, bus_rd, tick_24m, ext_rollover_in, cs_rx_valid, slow} = '0;
    {bus_addr, bus_wdata, cs_rx_time} = '0;
    phy_stat = '0;
    w = $urandom(32'hD4D8);
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'hE8);
    ck("nid_rst", 32'h0000FFFF, rv);
    rd(8'hEC);
    ck("pa_rst", 32'h0, rv);
    rd(8'h40);
    ck("unmapped", 32'h0, rv);
    for (int i = 0; i < 2; i++) begin
      idx = i ? 6'($urandom) : 6'h3F;
      @(posedge clk);
      phy_stat <= '{bus_reset: 1'b0, node_arrive: 1'b1, node_index: idx, is_root: i[0], cable_power: 1'b1};
      @(posedge clk);
      phy_stat.node_arrive <= 1'b0;
      rd(8'hE8);
      ck("nid_arrive", nid(1'b1, i[0], 1'b1, 10'h3FF, idx), rv);
      ck("unusable", {31'h0, idx == 6'h3F}, {31'h0, node_index_unusable});
      @(posedge clk);
      phy_stat <= '{bus_reset: 1'b1, node_arrive: 1'b0, node_index: idx, is_root: 1'b1, cable_power: 1'b0};
      @(posedge clk);
      phy_stat.bus_reset <= 1'b0;
      rd(8'hE8);
      ck("nid_breset", nid(1'b0, 1'b0, 1'b0, 10'h3FF, idx), rv);
    end
    w = $urandom;
    wr(8'hE8, w);
    rd(8'hE8);
    ck("nid_bus", nid(1'b0, 1'b0, 1'b0, w[15:6], idx), rv);
    ck("node_id", {16'h0, w[15:6], idx}, {16'h0, node_id});
    for (int i = 0; i < 4; i++) begin
      a = 4'($urandom);
      d = 8'($urandom);
      slow <= i[0];
      wr(8'hEC, {16'h0, 2'b01, 2'h0, a, d});
      poll(14, 1'b0);
      wr(8'hEC, {16'h0, 2'b10, 2'h0, a, 8'h0});
      poll(31, 1'b1);
      ck("phy_resp", {1'b1, 3'h0, a, d, 4'h0, a, 8'h0}, rv);
    end
    wr(8'hF4, 32'h0030_0000);
    wr(8'hF0, ctw(7'd127, 13'd7999, 12'd3070));
    tick_24m <= 1'b1;
    repeat (2) @(posedge clk);
    tick_24m <= 1'b0;
    rd(8'hF0);
    ck("ct_wrap", 32'h0, rv);
    ck("tx_time", 32'h0, cs_tx_time);
    wr(8'hF0, ctw(7'h05, 13'h0064, 12'hBFF));
    // A cycle start heard while master must not move the timer
    cs_rx_valid <= 1'b1;
    cs_rx_time <= 32'($urandom);
    tick_24m <= 1'b1;
    @(posedge clk);
    {cs_rx_valid, tick_24m} <= 2'b00;
    rd(8'hF0);
    ck("ct_master", ctw(7'h05, 13'h0065, 12'h000), rv);
    ck("tx_time2", ctw(7'h05, 13'h0065, 12'h000), cs_tx_time);
    wr(8'hF4, 32'h0010_0000);
    w = ctw(7'($urandom), 13'($urandom % 7999), 12'($urandom % 3000));
    cs_rx_valid <= 1'b1;
    cs_rx_time <= w;
    @(posedge clk);
    cs_rx_valid <= 1'b0;
    tick_24m <= 1'b1;
    repeat (3) @(posedge clk);
    tick_24m <= 1'b0;
    rd(8'hF0);
    ck("ct_load", w + 32'd3, rv);
    wr(8'hF4, 32'h0);
    tick_24m <= 1'b1;
    repeat (3) @(posedge clk);
    tick_24m <= 1'b0;
    rd(8'hF0);
    ck("ct_hold", w + 32'd3, rv);
    wr(8'hF4, 32'h0050_0000);
    tick_24m <= 1'b1;
    repeat (2) @(posedge clk);
    tick_24m <= 1'b0;
    ext_rollover_in <= 1'b1;
    @(posedge clk);
    ext_rollover_in <= 1'b0;
    rd(8'hF0);
    ck("ct_ext", {w[31:12] + 20'h1, 12'h0}, rv);
    ck("tx_count", 32'h2, 32'(tx_seen));
    conclude();
  end
endmodule
`default_nettype wire
